// ---- spicfg_top.sv ----
// Purpose: configuration and status register of a four-wire serial port,
//          with the slave-side shifter that feeds its status flags
// Assumes: byte-wide register bus with strobes, serial pins asynchronous
// Notes: link clock is sampled by clk, no second clock domain
// Behaviour
// R1 - busy reads one while any serial transfer runs, master or slave.
// R2 - role bit at position 6 selects slave when zero and master when one.
// R3 - phase bit at position 5 centres data on the first edge when zero, second when one.
// R4 - polarity bit at position 4 makes the serial clock idle low or high.
// R5 - selected flag reads one while the filtered select input is low, not the raw pin.
// R6 - position 2 returns the raw select pin level at the time of the read.
// R7 - in slave mode shifter-empty sets once bits are moved and nothing is pending.
// R8 - shifter-empty clears on a transmit load or a serial clock transition while selected.
// R9 - in slave mode receive-empty reads one once the buffer was read and holds nothing.
// R10 - receive-empty falls as soon as an unread byte sits in the receive buffer.
// R11 - in master mode shifter-empty and receive-empty read constantly one.
// R12 - as a slave, incoming data is sampled in the middle of each bit.
// R13 - writes to status positions have no effect; only role, phase, polarity store.
`timescale 1ns/1ps
module spicfg_top #(
   parameter int WIDTH = spicfg_pkg::DATA_BITS,
   parameter int FILTER = spicfg_pkg::GLITCH_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register bus
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // datapath hooks
   input wire logic master_busy,
   input wire logic tx_load,
   input wire logic [WIDTH-1:0] tx_data,
   // received data stream
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [WIDTH-1:0] rx_data,
   // serial pins
   input wire logic sck_pin,
   input wire logic mosi_pin,
   input wire logic slave_select_input,
   output logic miso_out,
   output logic miso_oe,
   // configuration outputs
   output logic master_role_select,
   output logic clock_phase_select,
   output logic clock_polarity_select
);
   initial begin
      if (WIDTH != 8) $error("width must be eight");
      if (FILTER < 1) $error("filter must be positive");
   end

   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   logic sck_s;
   logic mosi_s;
   logic raw_select_pin_level;
   logic sel_filt;
   spicfg_sync #(.FILTER(1), .RST_VAL(1'b0)) u_sck (
      .clk(clk), .rst(rst), .pin(sck_pin), .synced(sck_s), .filtered());
   spicfg_sync #(.FILTER(1), .RST_VAL(1'b0)) u_mosi (
      .clk(clk), .rst(rst), .pin(mosi_pin), .synced(mosi_s), .filtered());
   spicfg_sync #(.FILTER(FILTER), .RST_VAL(1'b1)) u_nss (
      .clk(clk), .rst(rst), .pin(slave_select_input),
      .synced(raw_select_pin_level), .filtered(sel_filt));

   // ---------------------------------------------
   // register write
   // ---------------------------------------------
   wire cfg_hit = (reg_addr == spicfg_pkg::SPICFG_ADDR);
   wire cfg_wr = cfg_hit && reg_wr;
   // only role, phase and polarity store
   always_ff @(posedge clk) begin
      if (rst) begin
         master_role_select <= spicfg_pkg::SPICFG_RESET[spicfg_pkg::BIT_MASTER];
         clock_phase_select <= spicfg_pkg::SPICFG_RESET[spicfg_pkg::BIT_PHASE];
         clock_polarity_select <= spicfg_pkg::SPICFG_RESET[spicfg_pkg::BIT_POLARITY];
      end else if (cfg_wr) begin // R13
         master_role_select <= reg_wdata[spicfg_pkg::BIT_MASTER]; // R2
         clock_phase_select <= reg_wdata[spicfg_pkg::BIT_PHASE]; // R3
         clock_polarity_select <= reg_wdata[spicfg_pkg::BIT_POLARITY]; // R4
      end
   end

   // ---------------------------------------------
   // slave clock edge detection
   // ---------------------------------------------
   logic sck_d;
   logic selected;
   always_ff @(posedge clk) begin
      if (rst) sck_d <= 1'b0;
      else sck_d <= sck_s;
   end
   assign selected = !master_role_select && !sel_filt;
   wire sck_edge = selected && (sck_s != sck_d);
   // leading edge leaves idle level, trailing edge returns to it
   wire lead_edge = sck_edge && (sck_s != clock_polarity_select); // R4
   wire sample_edge = clock_phase_select ? !lead_edge : lead_edge; // R3
   wire do_sample = sck_edge && sample_edge; // R12
   wire do_shift = sck_edge && !sample_edge;

   // ---------------------------------------------
   // slave shifter state
   // ---------------------------------------------
   spicfg_pkg::spicfg_state_t state;
   spicfg_pkg::spicfg_state_t next_state;
   logic [WIDTH-1:0] shreg;
   logic [3:0] bitcnt;
   logic tx_pending;
   logic [WIDTH-1:0] tx_hold;
   logic store_ready;
   logic buf_valid;
   wire last_bit = (bitcnt == 4'(WIDTH - 1));
   // transmit byte moves into the shifter only while idle
   wire load_shreg = (state == spicfg_pkg::SPICFG_IDLE) && tx_pending && !tx_load;
   // shifter holds a loaded byte not yet clocked out
   logic shreg_loaded;
   always_ff @(posedge clk) begin
      if (rst) shreg_loaded <= 1'b0;
      else if (load_shreg) shreg_loaded <= 1'b1;
      else if (state == spicfg_pkg::SPICFG_SHIFT) shreg_loaded <= 1'b0;
   end
   // next state of the slave shifter
   always_comb begin
      next_state = state;
      case (state)
         spicfg_pkg::SPICFG_IDLE: begin
            if (sck_edge) next_state = spicfg_pkg::SPICFG_SHIFT;
         end
         spicfg_pkg::SPICFG_SHIFT: begin
            if (sel_filt) next_state = spicfg_pkg::SPICFG_IDLE;
            else if (do_sample && last_bit) next_state = spicfg_pkg::SPICFG_STORE;
         end
         spicfg_pkg::SPICFG_STORE: begin
            if (store_ready) next_state = spicfg_pkg::SPICFG_IDLE;
         end
         default: next_state = spicfg_pkg::SPICFG_IDLE;
      endcase
   end
   // shift register, bit counter and transmit holding byte
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= spicfg_pkg::SPICFG_IDLE;
         shreg <= 8'h00;
         bitcnt <= 4'h0;
         tx_pending <= 1'b0;
         tx_hold <= 8'h00;
      end else begin
         state <= next_state;
         if (tx_load) begin
            tx_pending <= 1'b1;
            tx_hold <= tx_data;
         end
         if (load_shreg) begin
            shreg <= tx_hold;
            tx_pending <= 1'b0;
         end else if (do_sample) begin
            shreg <= {shreg[WIDTH-2:0], mosi_s}; // R12
            bitcnt <= last_bit ? 4'h0 : bitcnt + 4'h1;
         end
         if (sel_filt && state != spicfg_pkg::SPICFG_STORE) bitcnt <= 4'h0;
      end
   end
   assign miso_out = shreg[WIDTH-1];
   assign miso_oe = selected;

   // ---------------------------------------------
   // receive buffer
   // ---------------------------------------------
   wire rx_push = (state == spicfg_pkg::SPICFG_STORE);
   spicfg_buf2 #(.WIDTH(WIDTH)) u_rxbuf (
      .clk(clk), .rst(rst),
      .in_valid(rx_push), .in_ready(store_ready), .in_data(shreg),
      .out_valid(buf_valid), .out_ready(rx_ready), .out_data(rx_data));
   assign rx_valid = buf_valid;

   // ---------------------------------------------
   // shifter-empty flag
   // ---------------------------------------------
   logic shift_empty;
   // a loaded byte keeps the flag low until its bits have moved out
   wire shift_done = (state == spicfg_pkg::SPICFG_IDLE) && !tx_pending && !shreg_loaded;
   always_ff @(posedge clk) begin
      if (rst) shift_empty <= spicfg_pkg::SPICFG_RESET[spicfg_pkg::BIT_SHIFT_EMPTY];
      else if (tx_load || sck_edge) shift_empty <= 1'b0; // R8
      else if (shift_done) shift_empty <= 1'b1; // R7
   end

   // ---------------------------------------------
   // status assembly and read data
   // ---------------------------------------------
   wire busy = master_busy || (state != spicfg_pkg::SPICFG_IDLE); // R1
   wire sr_empty_view = master_role_select | shift_empty; // R11
   wire rx_empty_view = master_role_select | !buf_valid; // R9 R10 R11
   wire [7:0] status = {busy, master_role_select, clock_phase_select,
      clock_polarity_select, !sel_filt, raw_select_pin_level, // R5 R6
      sr_empty_view, rx_empty_view};
   // read data is latched from flip-flops on a read strobe
   always_ff @(posedge clk) begin
      if (rst) reg_rdata <= spicfg_pkg::SPICFG_RESET;
      else if (reg_rd) reg_rdata <= cfg_hit ? status : 8'h00;
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   sequence s_write_cfg;
      cfg_wr;
   endsequence
   chk_role_store: assert property (@(posedge clk) disable iff (rst) // R2
      s_write_cfg |=> master_role_select == $past(reg_wdata[6]))
      else $error("role bit not stored");
   chk_status_ro: assert property (@(posedge clk) disable iff (rst) // R13
      cfg_wr && reg_rd |=> reg_rdata[3] == $past(!sel_filt))
      else $error("status bit took write");
   chk_busy_view: assert property (@(posedge clk) disable iff (rst) // R1
      reg_rd && cfg_hit && master_busy |=> reg_rdata[7])
      else $error("busy not shown");
   chk_master_empty: assert property (@(posedge clk) disable iff (rst) // R11
      master_role_select |-> sr_empty_view && rx_empty_view)
      else $error("empty flags not one in master");
   chk_sel_filtered: assert property (@(posedge clk) disable iff (rst) // R5
      $changed(sel_filt) |-> $past(raw_select_pin_level) == sel_filt)
      else $error("selected flag tracks glitch");
   chk_raw_read: assert property (@(posedge clk) disable iff (rst) // R6
      reg_rd && cfg_hit |=> reg_rdata[2] == $past(raw_select_pin_level))
      else $error("raw level wrong");
   chk_sr_clear: assert property (@(posedge clk) disable iff (rst) // R8
      tx_load |=> !shift_empty)
      else $error("shifter empty not cleared");
   chk_rx_fall: assert property (@(posedge clk) disable iff (rst) // R10
      rx_push && store_ready && !master_role_select |=> !rx_empty_view)
      else $error("receive empty not cleared");
   chk_sample_mid: assert property (@(posedge clk) disable iff (rst) // R12
      do_shift && !load_shreg |=> $stable(shreg))
      else $error("data taken off centre");
   chk_sample_take: assert property (@(posedge clk) disable iff (rst) // R12
      do_sample && !load_shreg |=> shreg[0] == $past(mosi_s))
      else $error("sampled bit not stored");
endmodule // spicfg_top

// ---- spicfg_pkg.sv ----
// Purpose: constants shared by the serial port configuration/status block
// Assumes: byte-wide special-function register bus, one system clock
// Notes: bit positions and reset values of the configuration register
package spicfg_pkg;
   // ---------------------------------------------
   // register address and field positions
   // ---------------------------------------------
   localparam logic [7:0] SPICFG_ADDR = 8'hA1;
   localparam int BIT_BUSY = 7;
   localparam int BIT_MASTER = 6;
   localparam int BIT_PHASE = 5;
   localparam int BIT_POLARITY = 4;
   localparam int BIT_SELECTED = 3;
   localparam int BIT_RAW_SEL = 2;
   localparam int BIT_SHIFT_EMPTY = 1;
   localparam int BIT_RX_EMPTY = 0;
   // ---------------------------------------------
   // reset values and timing
   // ---------------------------------------------
   localparam logic [7:0] SPICFG_RESET = 8'h07;
   localparam int DATA_BITS = 8;
   localparam int GLITCH_CYCLES = 2;
   typedef enum logic [1:0] {
      SPICFG_IDLE = 2'b00,
      SPICFG_SHIFT = 2'b01,
      SPICFG_STORE = 2'b11
   } spicfg_state_t;
endpackage

// ---- spicfg_sync.sv ----
// Purpose: two-flop synchroniser with optional de-glitch for pin inputs
// Assumes: input from outside the clock domain, reset value given
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module spicfg_sync #(
   parameter int FILTER = 2,
   parameter logic RST_VAL = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pin side
   input wire logic pin,
   // outputs
   output logic synced,
   output logic filtered
);
   initial begin
      if (FILTER < 1 || FILTER > 15) $error("filter length out of range");
   end
   logic stage1;
   logic [3:0] count;
   // two-flop synchroniser
   always_ff @(posedge clk) begin
      if (rst) begin
         stage1 <= RST_VAL;
         synced <= RST_VAL;
      end else begin
         stage1 <= pin;
         synced <= stage1;
      end
   end
   // filtered copy changes only after the level has stood FILTER cycles
   always_ff @(posedge clk) begin
      if (rst) begin
         filtered <= RST_VAL;
         count <= 4'h0;
      end else if (synced == filtered) begin
         count <= 4'h0;
      end else if (count == 4'(FILTER - 1)) begin
         filtered <= synced;
         count <= 4'h0;
      end else begin
         count <= count + 4'h1;
      end
   end
endmodule // spicfg_sync

// ---- spicfg_buf2.sv ----
// Purpose: two-entry valid/ready buffer for received bytes
// Assumes: single clock
// Notes: full and empty are exact; in_ready low stalls the source
`timescale 1ns/1ps
module spicfg_buf2 #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   initial begin
      if (WIDTH < 1) $error("width must be positive");
   end
   logic [WIDTH-1:0] mem [2];
   logic rd_ptr;
   logic wr_ptr;
   logic [1:0] level;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // handshake and head of queue
   assign in_ready = (level != 2'h2);
   assign out_valid = (level != 2'h0);
   assign out_data = mem[rd_ptr];
   // storage, pointers and fill level
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         level <= 2'h0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr <= ~wr_ptr;
         end
         if (pop) rd_ptr <= ~rd_ptr;
         level <= level + 2'(push) - 2'(pop);
      end
   end
endmodule // spicfg_buf2

// ---- spicfg_master_model.sv ----
// Purpose: behavioural serial master that drives the slave-side pins
// Assumes: bit period 400 ns, clock stands still outside frames
// Notes: data line shows the inverse of its last bit once released
`timescale 1ns/1ps
module spicfg_master_model (
   // serial pins
   output logic sck,
   output logic mosi,
   output logic ss_n,
   input wire logic miso
);
   // idle pins at time zero
   initial begin
      sck = 1'b0;
      mosi = 1'b1;
      ss_n = 1'b1;
   end
   // ------------------------------------------
   // pin tasks
   // ------------------------------------------
   // one framed byte, msb first, data set half a period before its sampling edge
   task automatic frame(input logic [7:0] d, input logic pol, input logic pha,
                        output logic [7:0] q);
      int i;
      sck = pol;
      #400 ss_n = 1'b0;
      for (i = 7; i >= 0; i--) begin
         if (pha) sck = ~sck;
         mosi = d[i];
         #200 sck = ~sck;
         q[i] = miso;
         #200 if (!pha) sck = ~sck;
      end
      #200 ss_n = 1'b1;
      mosi = ~mosi;
      #400;
   endtask
   // select held at a level without clocking
   task automatic select(input logic lvl);
      ss_n = lvl;
   endtask
   // one clock-long low pulse on select
   task automatic glitch();
      ss_n = 1'b0;
      #50 ss_n = 1'b1;
   endtask
endmodule // spicfg_master_model

// ---- testbench.sv ----
// Purpose: self-checking bench for the serial port configuration block
// Assumes: register bus with one-cycle strobes, inputs driven at falling edge
// Notes: expected status bytes are built from the field positions
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] tx_data = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0, master_busy = 1'b0, tx_load = 1'b0, rx_ready = 1'b0;
   logic [7:0] reg_rdata, rx_data;
   logic rx_valid, sck, mosi, ss_n, miso_out, miso_oe, mrole, mpha, mpol;
   logic [7:0] pat [4] = '{8'hA5, 8'h3C, 8'h96, 8'h01};
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   wire logic miso_line = miso_oe ? miso_out : ~miso_out;
   // 20 MHz clock
   always #25 clk = ~clk;
   spicfg_top i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .master_busy(master_busy), .tx_load(tx_load), .tx_data(tx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .sck_pin(sck),
      .mosi_pin(mosi), .slave_select_input(ss_n), .miso_out(miso_out), .miso_oe(miso_oe),
      .master_role_select(mrole), .clock_phase_select(mpha), .clock_polarity_select(mpol));
   spicfg_master_model i_master (.sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso_line));
   // ------------------------------------------
   // tasks
   // ------------------------------------------
   task automatic complete_run();
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      q = reg_rdata;
   endtask
   // bounded wait for a received byte, then one pop strobe
   task automatic pop(output logic [7:0] q);
      int t;
      t = 0;
      @(negedge clk);
      while (rx_valid !== 1'b1 && t < 200) begin
         @(negedge clk);
         t++;
      end
      q = rx_data;
      rx_ready = 1'b1;
      @(negedge clk);
      rx_ready = 1'b0;
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         $display("[ERR] %0t run did not finish", $time);
         complete_run();
      end
   end
   // ------------------------------------------
   // main sequence
   // ------------------------------------------
   initial begin
      logic [7:0] q, m;
      int k;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      rd(8'hA1, q);
      chk(q, 8'h07);
      wr(8'hA1, 8'hFF);
      rd(8'hA1, q);
      chk(q, 8'h77);
      chk({5'h00, mrole, mpha, mpol}, 8'h07);
      master_busy = 1'b1;
      rd(8'hA1, q);
      chk(q, 8'hF7);
      master_busy = 1'b0;
      rd(8'hA2, q);
      chk(q, 8'h00);
      wr(8'hA1, 8'h00);
      i_master.glitch();
      repeat (8) @(negedge clk);
      rd(8'hA1, q);
      chk(q, 8'h07);
      chk({7'h00, miso_oe}, 8'h00);
      i_master.select(1'b0);
      repeat (8) @(negedge clk);
      chk({7'h00, miso_oe}, 8'h01);
      rd(8'hA1, q);
      chk(q & 8'h7F, 8'h0B);
      i_master.select(1'b1);
      tx_data = 8'hC3;
      tx_load = 1'b1;
      @(negedge clk);
      tx_load = 1'b0;
      rd(8'hA1, q);
      chk(q & 8'h02, 8'h00);
      // every phase and polarity pairing
      for (k = 0; k < 4; k++) begin
         wr(8'hA1, {2'b00, k[0], k[1], 4'h0});
         i_master.frame(pat[k], k[1], k[0], m);
         if (k == 0) chk(m, 8'hC3);
         rd(8'hA1, q);
         chk(q, {2'b00, k[0], k[1], 4'h6});
         pop(q);
         chk(q, pat[k]);
         rd(8'hA1, q);
         chk(q, {2'b00, k[0], k[1], 4'h7});
      end
      // three bytes into a two-entry buffer with no pops
      wr(8'hA1, 8'h00);
      for (k = 0; k < 3; k++) i_master.frame(pat[k], 1'b0, 1'b0, m);
      rd(8'hA1, q);
      chk(q & 8'h7F, 8'h04);
      for (k = 0; k < 3; k++) begin
         pop(q);
         chk(q, pat[k]);
      end
      rd(8'hA1, q);
      chk(q, 8'h07);
      complete_run();
   end
endmodule // testbench
